/* File: inc/scm_pkg.sv */
// Purpose: Constants and types for the single compare match output channel.
// Assumes: Registers reached over classic Wishbone with 32-bit data.
// Notes: Offsets are byte addresses of aligned words.
package scm_pkg;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CMP = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   localparam logic [3:0] ADDR_MASK = 4'hC;
   localparam int CTRL_ON_BIT = 15;
   localparam int CTRL_WIDE_BIT = 5;
   localparam int CTRL_TSEL_BIT = 3;
   localparam int CTRL_MODE_LSB = 0;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_802F;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam int STAT_MATCH_BIT = 0;
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_HIGH = 3'b001,
      MODE_LOW = 3'b010,
      MODE_TOGGLE = 3'b011
   } scm_mode_t;
endpackage

/* File: hdl/scm_match.sv */
`timescale 1ns/1ns
// Purpose: Count equality detector, one pulse per new count value.
// Assumes: Count and compare value are same-clock signals.
// Notes: A held count produces a single pulse only.
module scm_match (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [31:0] count,
   input wire logic [31:0] cmp,
   input wire logic wide,
   output logic hit
);
   import scm_pkg::*;
   typedef struct packed {
      logic [31:0] last;
      logic seen;
      logic hit;
   } scm_mst_t;
   scm_mst_t st;
   scm_mst_t next_st;
   logic eq;
   always_comb begin
      // Narrow mode ignores the upper halves in the equality test; repeat detection still uses the full count.
      eq = wide ? (count == cmp) : (count[15:0] == cmp[15:0]);
      next_st = st;
      next_st.seen = 1'b1;
      next_st.last = count;
      // A repeated count value does not re-fire.
      next_st.hit = eq && (!st.seen || count != st.last || !st.hit) && !(st.seen
         && count == st.last && eq);
      if (st.seen && count == st.last) begin
         next_st.hit = 1'b0;
      end else begin
         next_st.hit = eq;
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign hit = st.hit;
endmodule

/* File: hdl/scm_regs.sv */
`timescale 1ns/1ns
// Purpose: Wishbone classic slave holding control, compare, status and mask.
// Assumes: One ack per request, given one cycle after the request appears.
// Notes: Reading status clears it; a new event in that cycle wins.
module scm_regs (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic cyc,
   input wire logic stb,
   input wire logic we,
   input wire logic [3:0] adr,
   input wire logic [3:0] sel,
   input wire logic [31:0] dat_w,
   output logic [31:0] dat_r,
   output logic ack,
   input wire logic event_in,
   output logic [31:0] ctrl,
   output logic [31:0] cmp,
   output logic irq
);
   import scm_pkg::*;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] cmp;
      logic stat;
      logic mask;
      logic ack;
      logic [31:0] rd;
   } scm_rst_t;
   scm_rst_t st;
   scm_rst_t next_st;
   logic [31:0] bmask;
   logic go;
   always_comb begin
      bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      go = cyc && stb && !st.ack;
      next_st = st;
      next_st.ack = go;
      next_st.rd = RESET_WORD;
      if (go && we) begin
         unique case (adr)
            ADDR_CTRL: next_st.ctrl = (st.ctrl & ~(bmask & CTRL_WMASK))
               | (dat_w & bmask & CTRL_WMASK);
            ADDR_CMP: next_st.cmp = (st.cmp & ~bmask) | (dat_w & bmask);
            ADDR_MASK: if (sel[0]) next_st.mask = dat_w[STAT_MATCH_BIT];
            default: ;
         endcase
      end
      if (go && !we) begin
         unique case (adr)
            ADDR_CTRL: next_st.rd = st.ctrl;
            ADDR_CMP: next_st.rd = st.cmp;
            ADDR_STAT: begin
               next_st.rd = {31'h0000_0000, st.stat};
               next_st.stat = 1'b0;
            end
            ADDR_MASK: next_st.rd = {31'h0000_0000, st.mask};
            default: next_st.rd = RESET_WORD;
         endcase
      end
      // The event is applied last so it survives a clearing read.
      if (event_in) begin
         next_st.stat = 1'b1;
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign dat_r = st.rd;
   assign ack = st.ack;
   assign ctrl = st.ctrl;
   assign cmp = st.cmp;
   assign irq = st.stat && st.mask;
endmodule

/* File: hdl/scm_channel.sv */
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
// Purpose: Single compare match output channel with register access.
// Assumes: Timer counts arrive on CLK; timers are outside this block.
// Notes: Dual compare and PWM modes read back but drive no activity.
module scm_channel (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [31:0] FIRST_TIMER_COUNT,
   input wire logic [31:0] SECOND_TIMER_COUNT,
   input wire logic FIRST_TIMER_RUN,
   input wire logic SECOND_TIMER_RUN,
   output logic COMPARE_OUTPUT_PIN,
   output logic COMPARE_IRQ_FLAG,
   output logic IRQ
);
   import scm_pkg::*;
   typedef struct packed {
      logic pin;
      logic flag;
      logic [2:0] prev_mode;
      logic prev_on;
   } scm_cst_t;
   scm_cst_t st;
   scm_cst_t next_st;
   logic [31:0] ctrl;
   logic [31:0] cmp;
   logic [2:0] mode;
   logic on;
   logic tsel;
   logic run;
   logic hit;
   logic entry;
   logic active;
   logic [31:0] count;
   always_comb begin
      mode = ctrl[CTRL_MODE_LSB +: 3];
      on = ctrl[CTRL_ON_BIT];
      tsel = ctrl[CTRL_TSEL_BIT];
      count = tsel ? SECOND_TIMER_COUNT : FIRST_TIMER_COUNT;
      run = tsel ? SECOND_TIMER_RUN : FIRST_TIMER_RUN;
      // Only modes 001..011 are handled here.
      active = on && (mode == MODE_HIGH || mode == MODE_LOW || mode == MODE_TOGGLE);
      entry = active && (mode != st.prev_mode || !st.prev_on);
      next_st = st;
      next_st.prev_mode = mode;
      next_st.prev_on = on;
      next_st.flag = 1'b0;
      if (!active) begin
         next_st.pin = 1'b0;
      end else if (entry) begin
         next_st.pin = (mode == MODE_LOW);
      end else if (hit && run) begin
         unique case (mode)
            MODE_HIGH: begin
               // Only the changing match raises the flag.
               next_st.flag = !st.pin;
               next_st.pin = 1'b1;
            end
            MODE_LOW: begin
               next_st.flag = st.pin;
               next_st.pin = 1'b0;
            end
            default: begin
               next_st.flag = 1'b1;
               next_st.pin = !st.pin;
            end
         endcase
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   scm_match u_match (
      .CLK(CLK),
      .SRST(SRST),
      .count(count),
      .cmp(cmp),
      .wide(ctrl[CTRL_WIDE_BIT]),
      .hit(hit)
   );
   scm_regs u_regs (
      .CLK(CLK),
      .SRST(SRST),
      .cyc(WB_CYC_I),
      .stb(WB_STB_I),
      .we(WB_WE_I),
      .adr(WB_ADR_I),
      .sel(WB_SEL_I),
      .dat_w(WB_DAT_I),
      .dat_r(WB_DAT_O),
      .ack(WB_ACK_O),
      .event_in(st.flag),
      .ctrl(ctrl),
      .cmp(cmp),
      .irq(IRQ)
   );
   assign COMPARE_OUTPUT_PIN = st.pin;
   assign COMPARE_IRQ_FLAG = st.flag;

   a_high_on_match: assert property (@(posedge CLK) disable iff (SRST)
      $rose(COMPARE_OUTPUT_PIN) && mode == MODE_HIGH |-> COMPARE_IRQ_FLAG)
      else $error("High mode edge without flag.");
   a_low_on_match: assert property (@(posedge CLK) disable iff (SRST)
      $fell(COMPARE_OUTPUT_PIN) && mode == MODE_LOW && $past(active) |-> COMPARE_IRQ_FLAG)
      else $error("Low mode edge without flag.");
   a_toggle_flag: assert property (@(posedge CLK) disable iff (SRST)
      $past(active) && !$past(entry) && mode == MODE_TOGGLE && $past(mode) == MODE_TOGGLE
      && COMPARE_OUTPUT_PIN != $past(COMPARE_OUTPUT_PIN) |-> COMPARE_IRQ_FLAG)
      else $error("Toggle without flag.");
   a_off_quiet: assert property (@(posedge CLK) disable iff (SRST)
      !active |=> !COMPARE_OUTPUT_PIN && !COMPARE_IRQ_FLAG)
      else $error("Disabled channel shows activity.");
   a_entry_level: assert property (@(posedge CLK) disable iff (SRST)
      entry |=> COMPARE_OUTPUT_PIN == ($past(mode) == MODE_LOW))
      else $error("Wrong entry level.");
   a_match_delay: assert property (@(posedge CLK) disable iff (SRST)
      hit && run && active && !entry && mode == MODE_TOGGLE ##0 $stable(ctrl)
      |=> COMPARE_OUTPUT_PIN != $past(COMPARE_OUTPUT_PIN))
      else $error("Toggle missed after match.");
   a_flag_pulse: assert property (@(posedge CLK) disable iff (SRST)
      COMPARE_IRQ_FLAG |=> !COMPARE_IRQ_FLAG || mode == MODE_TOGGLE)
      else $error("Force mode flag repeated.");
   a_reset_zero: assert property (@(posedge CLK)
      SRST |=> !COMPARE_OUTPUT_PIN && !COMPARE_IRQ_FLAG)
      else $error("Output not zero after reset.");
   c_high: cover property (@(posedge CLK) mode == MODE_HIGH && $rose(COMPARE_OUTPUT_PIN));
   c_low: cover property (@(posedge CLK) mode == MODE_LOW && $fell(COMPARE_OUTPUT_PIN));
   c_toggle: cover property (@(posedge CLK) mode == MODE_TOGGLE && COMPARE_IRQ_FLAG
      ##[1:200] COMPARE_IRQ_FLAG);
endmodule

/* File: verif/scm_timer_model.sv */
`timescale 1ns/1ns
// Purpose: Behavioural time base that feeds a count to the compare channel.
// Assumes: Same clock as the channel; software may clear the count.
// Notes: The count holds while stopped, as a real timer does.
module scm_timer_model (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic run,
   input wire logic clr,
   input wire logic [31:0] period,
   output logic [31:0] count
);
   always_ff @(posedge CLK) begin
      if (SRST || clr) begin
         count <= 32'h0000_0000;
      end else if (run) begin
         count <= (count == period) ? 32'h0000_0000 : count + 32'h0000_0001;
      end
   end
endmodule

/* File: verif/test_scm_channel.sv */
`timescale 1ns/1ns
// Purpose: Self-checking bench for the compare channel over Wishbone.
// Assumes: Ack comes one cycle after a request; counts share CLK.
// Notes: The first timer wraps at 3 so it never reaches a compare of 5.
module test_scm_channel;
   import scm_pkg::*;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, r1 = 1'b0, r2 = 1'b0, tclr = 1'b1;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, q, c1, c2, rdat;
   logic ack, pin, flag, irq;
   int failures = 0, n_tests = 0;
   always #10 CLK = ~CLK;
   scm_timer_model u_t1 (.CLK(CLK), .SRST(SRST), .run(r1), .clr(tclr),
      .period(32'h0000_0003), .count(c1));
   scm_timer_model u_t2 (.CLK(CLK), .SRST(SRST), .run(r2), .clr(tclr),
      .period(32'h0000_0009), .count(c2));
   scm_channel u_scm_channel (.CLK(CLK), .SRST(SRST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .FIRST_TIMER_COUNT(c1), .SECOND_TIMER_COUNT(c2),
      .FIRST_TIMER_RUN(r1), .SECOND_TIMER_RUN(r2), .COMPARE_OUTPUT_PIN(pin),
      .COMPARE_IRQ_FLAG(flag), .IRQ(irq));
   task finish_test;
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task check(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Holds the request until ack is seen high at a rising edge, then releases.
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge CLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= d;
      // Ack and read data are read as they stood at the edge, before it updates them.
      do begin
         @(posedge CLK);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         failures++;
         finish_test();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // Reprograms the channel from off, checks the entry level, then counts
   // interrupt pulses and output edges over six periods of the second timer.
   task run_mode(input logic [31:0] c, input logic [31:0] cmpv, input logic go,
                 input logic entry, input int n);
      int nf, ne;
      logic last;
      @(posedge CLK);
      r1 <= 1'b0;
      r2 <= 1'b0;
      tclr <= 1'b1;
      wb(1'b1, ADDR_CTRL, 32'h0000_0000);
      wb(1'b1, ADDR_CMP, cmpv);
      wb(1'b1, ADDR_CTRL, c);
      repeat (2) @(posedge CLK);
      #1;
      check("entry level", pin, entry);
      last = pin;
      nf = 0;
      ne = 0;
      @(posedge CLK);
      tclr <= 1'b0;
      r1 <= go;
      r2 <= go;
      repeat (60) begin
         @(posedge CLK);
         #1;
         if (flag === 1'b1) nf++;
         if (pin !== last) ne++;
         last = pin;
      end
      check("irq pulses", nf, n);
      check("pin edges", ne, n);
   endtask
   initial begin
      repeat (2) @(posedge CLK);
      SRST <= 1'b0;
      #1;
      check("pin at reset", pin, 1'b0);
      check("flag at reset", {irq, flag}, 2'b00);
      wb(1'b0, ADDR_CMP, 32'h0000_0000);
      check("compare reset", q, RESET_WORD);
      wb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
      wb(1'b0, ADDR_CTRL, 32'h0000_0000);
      check("control bits", q, CTRL_WMASK);
      wb(1'b1, ADDR_MASK, 32'h0000_0001);
      run_mode(32'h0000_8001, 32'h0000_0002, 1'b1, 1'b0, 1);
      check("irq level", irq, 1'b1);
      wb(1'b0, ADDR_STAT, 32'h0000_0000);
      check("status set", q, 32'h0000_0001);
      wb(1'b0, ADDR_STAT, 32'h0000_0000);
      check("status cleared", {q[0], irq}, 2'b00);
      run_mode(32'h0000_8002, 32'h0000_0002, 1'b1, 1'b1, 1);
      run_mode(32'h0000_800B, 32'h0000_0005, 1'b1, 1'b0, 6);
      run_mode(32'h0000_8003, 32'h0000_0005, 1'b1, 1'b0, 0);
      run_mode(32'h0000_800B, 32'h0001_0005, 1'b1, 1'b0, 6);
      run_mode(32'h0000_802B, 32'h0001_0005, 1'b1, 1'b0, 0);
      run_mode(32'h0000_000B, 32'h0000_0005, 1'b1, 1'b0, 0);
      run_mode(32'h0000_8000, 32'h0000_0005, 1'b1, 1'b0, 0);
      // The held count equals the compare value here, yet the stopped timer must not toggle.
      run_mode(32'h0000_800B, 32'h0000_0000, 1'b0, 1'b0, 0);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge CLK);
      failures++;
      finish_test();
   end
endmodule
